// >>> core/host_port_pkg.sv
package host_port_pkg;

    // =====================================================================
    // widths
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 3;
    localparam int CHAN_W   = 2;
    localparam int NUM_CHAN = 4;

    // =====================================================================
    // bus mode encoding of the mode-select pin
    localparam logic MODE_SPLIT   = 1'b0;
    localparam logic MODE_DSTROBE = 1'b1;

    // =====================================================================
    // bit positions in the synchronised pin vector
    localparam int SY_DATA = 0;
    localparam int SY_ADDR = 8;
    localparam int SY_LO   = 11;
    localparam int SY_HI   = 12;
    localparam int SY_RNW  = 13;
    localparam int SY_DS   = 14;
    localparam int SY_RD   = 15;
    localparam int SY_WR   = 16;
    localparam int SY_CS   = 17;
    localparam int SY_RST  = 21;
    localparam int SY_MODE = 22;
    localparam int SYNC_W  = 23;

    // =====================================================================
    // reset values: strobes and selects idle high, mode split
    localparam logic [SYNC_W-1:0] SYNC_RST_VAL  = 23'h1fc000;
    localparam logic              CHAN_RST_VAL  = 1'b1;
    localparam logic              OE_N_RST_VAL  = 1'b1;

    // =====================================================================
    // access sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } access_state_type;

endpackage : host_port_pkg

// >>> core/dual_mode_host_bus_port.sv
`timescale 1ns/100ps
`default_nettype none

module dual_mode_host_bus_port (
    // clock and reset
    input  wire  logic                                 clk,
    input  wire  logic                                 sys_rst,
    // static configuration and chip reset pin
    input  wire  logic                                 bus_mode_sel,
    input  wire  logic                                 hw_reset_pin,
    // split-strobe pins
    input  wire  logic [host_port_pkg::NUM_CHAN-1:0]   chan_sel_n,
    input  wire  logic                                 write_strobe_n,
    input  wire  logic                                 read_strobe_n,
    // data-strobe pins
    input  wire  logic                                 data_strobe_n,
    input  wire  logic                                 read_not_write,
    input  wire  logic                                 chan_addr_hi,
    input  wire  logic                                 chan_addr_lo,
    // shared address and data bus
    input  wire  logic [host_port_pkg::ADDR_W-1:0]     reg_addr_pins,
    input  wire  logic [host_port_pkg::DATA_W-1:0]     host_data_bus_in,
    output logic       [host_port_pkg::DATA_W-1:0]     host_data_bus_out,
    output logic                                       host_data_bus_oe_n,
    // channel register side
    output logic                                       chan_reset,
    output logic                                       reg_wr_pulse,
    output logic                                       reg_rd_pulse,
    output logic       [host_port_pkg::CHAN_W-1:0]     reg_chan,
    output logic       [host_port_pkg::ADDR_W-1:0]     reg_addr,
    output logic       [host_port_pkg::DATA_W-1:0]     reg_wdata,
    input  wire  logic [host_port_pkg::DATA_W-1:0]     reg_rdata
);

    // =====================================================================
    // module state
    typedef struct packed {
        host_port_pkg::access_state_type    state;
        logic [host_port_pkg::SYNC_W-1:0]   meta;
        logic [host_port_pkg::SYNC_W-1:0]   sync;
        logic                               chan_reset;
        logic                               wr_pulse;
        logic                               rd_pulse;
        logic [host_port_pkg::CHAN_W-1:0]   chan;
        logic [host_port_pkg::ADDR_W-1:0]   addr;
        logic [host_port_pkg::DATA_W-1:0]   wdata;
        logic [host_port_pkg::DATA_W-1:0]   dout;
        logic                               oe_n;
    } port_state_type;

    port_state_type cur;
    port_state_type next_cur;

    // decoded view of the synchronised pins
    logic                               ds_mode;
    logic                               pin_rst_active;
    logic [host_port_pkg::NUM_CHAN-1:0] sel;
    logic                               sel_one;
    logic                               rd_low;
    logic                               wr_low;
    logic                               access;
    logic                               is_read;
    logic [host_port_pkg::CHAN_W-1:0]   dec_chan;
    logic [host_port_pkg::ADDR_W-1:0]   dec_addr;

    // =====================================================================
    // pin decode, only the second sync stage is read
    always_comb begin
        ds_mode  = cur.sync[host_port_pkg::SY_MODE] == host_port_pkg::MODE_DSTROBE;
        pin_rst_active = ds_mode ? !cur.sync[host_port_pkg::SY_RST]
                                 :  cur.sync[host_port_pkg::SY_RST];
        sel      = ~cur.sync[host_port_pkg::SY_CS +: host_port_pkg::NUM_CHAN];
        sel_one  = $onehot(sel);
        rd_low   = !cur.sync[host_port_pkg::SY_RD];
        wr_low   = !cur.sync[host_port_pkg::SY_WR];
        dec_addr = cur.sync[host_port_pkg::SY_ADDR +: host_port_pkg::ADDR_W];
        dec_chan = '0;
        if (ds_mode) begin
            dec_chan = {cur.sync[host_port_pkg::SY_HI],
                        cur.sync[host_port_pkg::SY_LO]};
            access   = !cur.sync[host_port_pkg::SY_DS];
            is_read  = cur.sync[host_port_pkg::SY_RNW];
        end else begin
            // both strobes low at once is ambiguous, so it is ignored
            access   = sel_one && (rd_low ^ wr_low);
            is_read  = rd_low;
            if (sel[1]) begin
                dec_chan = 2'h1;
            end else if (sel[2]) begin
                dec_chan = 2'h2;
            end else if (sel[3]) begin
                dec_chan = 2'h3;
            end
        end
    end

    // =====================================================================
    // access sequencer
    always_comb begin
        next_cur            = cur;
        next_cur.meta       = {bus_mode_sel, hw_reset_pin, chan_sel_n, write_strobe_n,
                               read_strobe_n, data_strobe_n, read_not_write, chan_addr_hi,
                               chan_addr_lo, reg_addr_pins, host_data_bus_in};
        next_cur.sync       = cur.meta;
        next_cur.chan_reset = pin_rst_active;
        next_cur.wr_pulse   = 1'b0;
        next_cur.rd_pulse   = 1'b0;
        if (pin_rst_active) begin
            // chip reset aborts any access and floats the bus
            next_cur.state = host_port_pkg::ST_IDLE;
            next_cur.oe_n  = 1'b1;
        end else begin
            case (cur.state)
                host_port_pkg::ST_IDLE: begin
                    if (access) begin
                        next_cur.chan = dec_chan;
                        next_cur.addr = dec_addr;
                        if (is_read) begin
                            next_cur.state    = host_port_pkg::ST_READ;
                            next_cur.rd_pulse = 1'b1;
                        end else begin
                            next_cur.state = host_port_pkg::ST_WRITE;
                            next_cur.wdata =
                                cur.sync[host_port_pkg::SY_DATA +: host_port_pkg::DATA_W];
                        end
                    end
                end
                host_port_pkg::ST_READ: begin
                    // drive while the read lasts; data follows the register
                    next_cur.oe_n = 1'b0;
                    next_cur.dout = reg_rdata;
                    if (!access) begin
                        next_cur.state = host_port_pkg::ST_IDLE;
                        next_cur.oe_n  = 1'b1;
                    end
                end
                host_port_pkg::ST_WRITE: begin
                    if (access) begin
                        // keep the last value seen before the strobe rises
                        next_cur.wdata = cur.sync[host_port_pkg::SY_DATA +: host_port_pkg::DATA_W];
                    end else begin
                        next_cur.state    = host_port_pkg::ST_IDLE;
                        next_cur.wr_pulse = 1'b1;
                    end
                end
                default: begin
                    next_cur.state = host_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // =====================================================================
    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur            <= '0;
            cur.state      <= host_port_pkg::ST_IDLE;
            cur.meta       <= host_port_pkg::SYNC_RST_VAL;
            cur.sync       <= host_port_pkg::SYNC_RST_VAL;
            cur.chan_reset <= host_port_pkg::CHAN_RST_VAL;
            cur.oe_n       <= host_port_pkg::OE_N_RST_VAL;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs come straight from the state register
    assign host_data_bus_out  = cur.dout;
    assign host_data_bus_oe_n = cur.oe_n;
    assign chan_reset         = cur.chan_reset;
    assign reg_wr_pulse       = cur.wr_pulse;
    assign reg_rd_pulse       = cur.rd_pulse;
    assign reg_chan           = cur.chan;
    assign reg_addr           = cur.addr;
    assign reg_wdata          = cur.wdata;

    // =====================================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic start_ok;
    assign start_ok = (cur.state == host_port_pkg::ST_IDLE) && !pin_rst_active && access;

    AST_RST_SPLIT: assert property (
        !ds_mode && cur.sync[host_port_pkg::SY_RST] |=> chan_reset)
        else $error("split mode high reset pin did not reset channels");
    AST_RST_DSTROBE: assert property (
        ds_mode && !cur.sync[host_port_pkg::SY_RST] |=> chan_reset)
        else $error("data-strobe mode low reset pin did not reset channels");
    AST_ONE_SELECT: assert property (
        !ds_mode && !sel_one |=> !reg_rd_pulse && cur.state != host_port_pkg::ST_WRITE)
        else $error("access started without exactly one select");
    AST_ADDR_LATCH: assert property (
        start_ok |=> reg_addr == $past(dec_addr))
        else $error("register address not latched at access start");
    AST_WRITE_END: assert property (
        reg_wr_pulse |-> $past(cur.state == host_port_pkg::ST_WRITE) && $past(!access))
        else $error("write pulse without a finished write access");
    AST_READ_DRIVE: assert property (
        start_ok && is_read |=> reg_rd_pulse ##1 !host_data_bus_oe_n)
        else $error("read access did not drive the bus in two cycles");
    AST_DS_IDLE: assert property (
        ds_mode && cur.sync[host_port_pkg::SY_DS] && cur.state == host_port_pkg::ST_IDLE
        |=> !reg_rd_pulse && cur.state == host_port_pkg::ST_IDLE)
        else $error("access started with data strobe high");
    AST_DS_CHAN: assert property (
        ds_mode && start_ok
        |=> reg_chan == $past({cur.sync[host_port_pkg::SY_HI], cur.sync[host_port_pkg::SY_LO]}))
        else $error("channel not decoded from upper address bits");
    AST_READ_DATA: assert property (
        !host_data_bus_oe_n |-> host_data_bus_out == $past(reg_rdata))
        else $error("bus data does not follow the register");
    AST_FLOAT: assert property (
        !host_data_bus_oe_n |-> $past(cur.state == host_port_pkg::ST_READ) && !chan_reset)
        else $error("bus driven outside a read access");

    COV_SPLIT_WRITE: cover property (!ds_mode && reg_wr_pulse);
    COV_SPLIT_READ:  cover property (!ds_mode && !host_data_bus_oe_n ##1 host_data_bus_oe_n);
    COV_DS_WRITE:    cover property (ds_mode && reg_wr_pulse && reg_chan == 2'h3);
    COV_DS_READ:     cover property (ds_mode && reg_rd_pulse);

endmodule : dual_mode_host_bus_port

`default_nettype wire

// >>> sim/host_bus_model.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// host processor model: pins change just after an edge, then hold
module host_bus_model (
    // clock and bus mode
    input  wire logic       clk,
    input  wire logic       mode,
    // host control pins
    output logic [3:0]      chan_sel_n,
    output logic            write_strobe_n,
    output logic            read_strobe_n,
    output logic            data_strobe_n,
    output logic            read_not_write,
    output logic            chan_addr_hi,
    output logic            chan_addr_lo,
    output logic [2:0]      reg_addr_pins,
    // resolved data bus
    output logic [7:0]      bus_in,
    input  wire logic [7:0] bus_out,
    input  wire logic       bus_oe_n
);
    logic [7:0] host_d;
    logic       host_en;

    // a floating bus shows the inverse of the last byte so stale data cannot match
    assign bus_in = !bus_oe_n ? bus_out : (host_en ? host_d : ~host_d);

    // idle levels: every strobe and select high
    initial begin
        {chan_sel_n, write_strobe_n, read_strobe_n, data_strobe_n} = 7'h7f;
        {read_not_write, chan_addr_hi, chan_addr_lo, reg_addr_pins} = 6'h20;
        host_d = 8'h00;
        host_en = 1'b0;
    end

    // one byte access; address, select and direction set up 3 cycles early
    task automatic access(input logic rd, input logic [3:0] sel_n, input logic [1:0] ch,
                          input logic [2:0] a, input logic [7:0] wd, output logic [7:0] got);
        @(posedge clk);
        reg_addr_pins <= a;
        chan_sel_n <= mode ? 4'hf : sel_n;
        {chan_addr_hi, chan_addr_lo} <= ch;
        read_not_write <= rd;
        host_d <= wd;
        host_en <= !rd;
        repeat (3) @(posedge clk);
        if (mode) data_strobe_n <= 1'b0;
        else if (rd) read_strobe_n <= 1'b0;
        else write_strobe_n <= 1'b0;
        repeat (7) @(posedge clk);
        got = bus_in;
        {chan_sel_n, write_strobe_n, read_strobe_n, data_strobe_n} <= 7'h7f;
        host_en <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : access
endmodule : host_bus_model

`default_nettype wire

// >>> sim/dual_mode_host_bus_port_bench.sv
`timescale 1ns/100ps
`default_nettype none

module dual_mode_host_bus_port_bench;
    logic       clk, sys_rst, bus_mode_sel, hw_reset_pin, write_strobe_n, read_strobe_n;
    logic       data_strobe_n, read_not_write, chan_addr_hi, chan_addr_lo, oe_n, chan_reset;
    logic       reg_wr_pulse, reg_rd_pulse;
    logic [3:0] chan_sel_n;
    logic [2:0] reg_addr_pins, reg_addr;
    logic [1:0] reg_chan;
    logic [7:0] bus_in, bus_out, reg_wdata, reg_rdata, got;
    logic [7:0] chan_regs [4][8];
    int         mismatches, total_checks, wr_count, rd_count, cycles;

    dual_mode_host_bus_port dut (.clk(clk), .sys_rst(sys_rst), .bus_mode_sel(bus_mode_sel),
        .hw_reset_pin(hw_reset_pin), .chan_sel_n(chan_sel_n), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .data_strobe_n(data_strobe_n),
        .read_not_write(read_not_write), .chan_addr_hi(chan_addr_hi),
        .chan_addr_lo(chan_addr_lo), .reg_addr_pins(reg_addr_pins), .host_data_bus_in(bus_in),
        .host_data_bus_out(bus_out), .host_data_bus_oe_n(oe_n), .chan_reset(chan_reset),
        .reg_wr_pulse(reg_wr_pulse), .reg_rd_pulse(reg_rd_pulse), .reg_chan(reg_chan),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    host_bus_model host (.clk(clk), .mode(bus_mode_sel), .chan_sel_n(chan_sel_n),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .data_strobe_n(data_strobe_n), .read_not_write(read_not_write),
        .chan_addr_hi(chan_addr_hi), .chan_addr_lo(chan_addr_lo),
        .reg_addr_pins(reg_addr_pins), .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(oe_n));

    // =====================================================================
    // channel registers behind the port, plus pulse counts and cycle count
    assign reg_rdata = chan_regs[reg_chan][reg_addr];
    always @(posedge clk) begin
        cycles++;
        if (reg_wr_pulse === 1'b1) begin
            wr_count++;
            chan_regs[reg_chan][reg_addr] <= reg_wdata;
        end
        if (reg_rd_pulse === 1'b1) begin
            rd_count++;
        end
    end

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] val, input logic [7:0] exp, input string what);
        total_checks++;
        if (val !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, val, exp);
        end
    endtask : chk

    // =====================================================================
    // scenarios
    task automatic split_rw();
        for (int ch = 0; ch < 4; ch++) begin
            host.access(1'b0, ~(4'h1 << ch), 2'h0, 3'(ch + 2), 8'h5a ^ 8'(ch), got);
            chk(8'(wr_count), 8'(ch + 1), "split write count");
            chk({6'h00, reg_chan}, 8'(ch), "split channel");
            chk({5'h00, reg_addr}, 8'(ch + 2), "split address");
        end
        for (int ch = 3; ch >= 0; ch--) begin
            host.access(1'b1, ~(4'h1 << ch), 2'h0, 3'(ch + 2), 8'h00, got);
            chk(got, 8'h5a ^ 8'(ch), "split read data");
            chk(8'(rd_count), 8'(4 - ch), "split read pulse count");
            chk({7'h00, oe_n}, 8'h01, "bus released after read");
        end
        $display("test split_rw finished");
    endtask : split_rw

    task automatic refused();
        host.access(1'b0, 4'h3, 2'h0, 3'h1, 8'hc3, got);
        host.access(1'b0, 4'hf, 2'h0, 3'h1, 8'hc3, got);
        chk(8'(wr_count), 8'h04, "write without single select");
        host.access(1'b1, 4'hf, 2'h0, 3'h1, 8'h00, got);
        // a floating bus reads back as the inverse of the host byte
        chk(got, 8'hff, "unselected read floats bus");
        chk(8'(rd_count), 8'h04, "read without select");
        chk({7'h00, oe_n}, 8'h01, "unselected read drives bus");
        $display("test refused finished");
    endtask : refused

    task automatic pin_reset();
        hw_reset_pin <= 1'b1;
        repeat (5) @(posedge clk);
        chk({7'h00, chan_reset}, 8'h01, "split reset high");
        hw_reset_pin <= 1'b0;
        repeat (5) @(posedge clk);
        chk({7'h00, chan_reset}, 8'h00, "split reset low");
        bus_mode_sel <= 1'b1;
        hw_reset_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk({7'h00, chan_reset}, 8'h00, "strobe mode reset high");
        hw_reset_pin <= 1'b0;
        repeat (5) @(posedge clk);
        chk({7'h00, chan_reset}, 8'h01, "strobe mode reset low");
        hw_reset_pin <= 1'b1;
        repeat (8) @(posedge clk);
        $display("test pin_reset finished");
    endtask : pin_reset

    task automatic ds_rw();
        for (int ch = 0; ch < 4; ch++) begin
            host.access(1'b0, 4'hf, 2'(ch), 3'(7 - ch), 8'ha0 + 8'(ch), got);
            chk({6'h00, reg_chan}, 8'(ch), "strobe mode channel");
            chk({5'h00, reg_addr}, 8'(7 - ch), "strobe mode address");
            chk(8'(wr_count), 8'(ch + 5), "strobe mode write count");
        end
        for (int ch = 0; ch < 4; ch++) begin
            host.access(1'b1, 4'hf, 2'(ch), 3'(7 - ch), 8'h00, got);
            chk(got, 8'ha0 + 8'(ch), "strobe mode read data");
            chk(8'(rd_count), 8'(ch + 5), "strobe mode read pulse count");
        end
        $display("test ds_rw finished");
    endtask : ds_rw

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial begin
        {mismatches, total_checks, wr_count, rd_count, cycles} = '0;
        foreach (chan_regs[i, j]) chan_regs[i][j] = 8'h00;
        sys_rst = 1'b1;
        bus_mode_sel = 1'b0;
        hw_reset_pin = 1'b0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        fork
            begin
                split_rw();
                refused();
                pin_reset();
                ds_rw();
            end
            begin
                // hang guard, far beyond the few hundred cycles the tests need
                while (cycles < 4000) @(posedge clk);
                mismatches++;
                $display("wrong value at %0t: run timed out", $time);
            end
        join_any
        tally_and_finish();
    end
endmodule : dual_mode_host_bus_port_bench

`default_nettype wire
